/* hw/dcm_cfg.svh */
// Register map, field positions, reset values and timing figures of the compare unit.
`ifndef DCM_CFG_SVH
`define DCM_CFG_SVH

// Register byte offsets on the plain register port.
`define DCM_ADDR_W          8
`define DCM_OFF_CTRL        8'h00
`define DCM_OFF_STATUS      8'h04
`define DCM_OFF_CMP_A       8'h08
`define DCM_OFF_CMP_B       8'h0C
`define DCM_OFF_CFG_A       8'h10
`define DCM_OFF_CFG_B       8'h14
`define DCM_OFF_INT_STATUS  8'h18
`define DCM_OFF_INT_MASK    8'h1C

// Control register fields.
`define DCM_CTRL_ENABLE     0
`define DCM_CTRL_UPDATE     1

// Status register fields.
`define DCM_ST_MATCH_A      0
`define DCM_ST_MATCH_B      1
`define DCM_ST_FAULT        2
`define DCM_ST_CODE_LO      8
`define DCM_ST_OUT_LO       16

// Comparator configuration fields.
`define DCM_CFG_ACT_LO      0
`define DCM_CFG_SEL_LO      4
`define DCM_CFG_EVT_LO      16

// Interrupt bit positions.
`define DCM_IRQ_MATCH_A     0
`define DCM_IRQ_MATCH_B     1
`define DCM_IRQ_FAULT       2

// Field widths and value ranges.
`define DCM_ACT_W           4
`define DCM_SEL_W           2
`define DCM_EVT_W           9
`define DCM_CODE_W          4
`define DCM_NUM_OUT         4
`define DCM_NUM_EVT         32
`define DCM_EVT_NONE        9'h000
`define DCM_EVT_BASE        9'h190
`define DCM_EVT_LAST        9'h1AF
`define DCM_ACT_MAX         4'h8

// Reset values.
`define DCM_RST_WORD        32'h0000_0000
`define DCM_RST_IRQ         3'h0

// Longest allowed delay from match to action, and the clock period.
`define DCM_ACTION_MAX_NS   100000
`define DCM_CLK_PERIOD_NS   5
`define DCM_ACTION_MAX_CYC  (`DCM_ACTION_MAX_NS / `DCM_CLK_PERIOD_NS)

`endif

/* hw/dcm_pkg.sv */
// Types shared by the compare unit modules.
package dcm_pkg;

  // Match action codes.
  typedef enum logic [3:0] {
    ACT_NONE       = 4'h0,
    ACT_LOW        = 4'h1,
    ACT_HIGH       = 4'h2,
    ACT_TOGGLE     = 4'h3,
    ACT_LOW_CLR    = 4'h4,
    ACT_HIGH_CLR   = 4'h5,
    ACT_TOGGLE_CLR = 4'h6,
    ACT_CLR        = 4'h7,
    ACT_CLR_BOTH   = 4'h8
  } action_t;

  // Fault codes shown in the status register.
  typedef enum logic [3:0] {
    FAULT_NONE   = 4'h0,
    FAULT_ACTION = 4'h1,
    FAULT_EVENT  = 4'h2,
    FAULT_EQUAL  = 4'h3
  } fault_t;

  // Run state of the unit, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_FAULT = 3'b100
  } run_state_t;

  // An event select is legal when zero or inside the external event window.
  function automatic logic event_sel_ok(input logic [8:0] sel);
    event_sel_ok = (sel == 9'h000) || ((sel >= 9'h190) && (sel <= 9'h1AF));
  endfunction

  // The action code clears the counter for codes four to eight.
  function automatic logic action_clears(input logic [3:0] act);
    action_clears = (act >= 4'h4) && (act <= 4'h8);
  endfunction

endpackage

/* hw/match_detect.sv */
// Pulse-input compare arrival detector for one comparator.
`timescale 1ns/1ps
module match_detect
(
  input  wire logic [31:0] i_prev,   // Counter value one cycle ago.
  input  wire logic [31:0] i_cur,    // Counter value now.
  input  wire logic [31:0] i_cmp,    // Active compare value.
  output logic             o_hit     // High in the cycle the value leaves the compare value.
);

  // Arrival counts as the value leaving the compare value by one step in either direction.
  always_comb
  begin
    o_hit = (i_prev == i_cmp) && ((i_cur == i_cmp + 32'h0000_0001) ||
                                  (i_cur == i_cmp - 32'h0000_0001));
  end

endmodule

/* hw/event_decode.sv */
// Decoder from an event select value to one of the 32 external event lines.
`timescale 1ns/1ps
`include "dcm_cfg.svh"
module event_decode
(
  input  wire logic                     i_fire,  // One-cycle match pulse.
  input  wire logic [`DCM_EVT_W-1:0]    i_sel,   // Active event select.
  output logic      [`DCM_NUM_EVT-1:0]  o_lines  // One-hot event request.
);

  logic [`DCM_EVT_W-1:0] offset;  // Line number inside the window.

  // Zero or an out-of-window value raises nothing.
  always_comb
  begin
    offset  = i_sel - `DCM_EVT_BASE;
    o_lines = '0;
    if (i_fire && (i_sel != `DCM_EVT_NONE) && (i_sel >= `DCM_EVT_BASE)
        && (i_sel <= `DCM_EVT_LAST))
    begin
      o_lines[offset[4:0]] = 1'b1;
    end
  end

endmodule

/* hw/dual_compare_match_output.sv */
// Two-comparator match unit driving four output points and 32 event lines.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "dcm_cfg.svh"
module dual_compare_match_output
(
  input  wire logic                     i_clk,            // 200 MHz counter module clock.
  input  wire logic                     i_rst_n,          // Asynchronous reset, active low.
  input  wire logic                     i_ce,             // Clock enable; low freezes all state.
  input  wire logic [`DCM_ADDR_W-1:0]   i_addr,           // Register byte address.
  input  wire logic [31:0]              i_wdata,          // Register write data.
  input  wire logic                     i_wr,             // Write strobe.
  input  wire logic                     i_rd,             // Read strobe.
  output logic      [31:0]              o_rdata,          // Read data, one cycle after i_rd.
  input  wire logic [31:0]              i_count,          // Channel counter value.
  input  wire logic                     i_counter_run_enable, // Channel counter is counting.
  input  wire logic                     i_counter_cleared,    // Counter was cleared elsewhere.
  input  wire logic                     i_host_stop,      // Host controller stopped.
  output logic                          o_counter_clear,  // One-cycle request to zero the counter.
  output logic      [`DCM_NUM_OUT-1:0]  o_out,            // Output points zero to three.
  output logic      [`DCM_NUM_EVT-1:0]  o_event,          // One-cycle external event lines.
  output logic                          o_irq             // Level interrupt.
);
  import dcm_pkg::*;

  // Software-side staging copies, written at any time.
  logic [31:0]             cmp_a_q;     // Staged compare_value_a.
  logic [31:0]             cmp_b_q;     // Staged compare_value_b.
  logic [31:0]             cfg_a_q;     // Staged action, selector and event of comparator a.
  logic [31:0]             cfg_b_q;     // Staged action, selector and event of comparator b.
  // Active copies, the ones the comparators use.
  logic [31:0]             act_cmp_a_q; // Active compare_value_a.
  logic [31:0]             act_cmp_b_q; // Active compare_value_b.
  logic [`DCM_ACT_W-1:0]   action_code_a_q;
  logic [`DCM_ACT_W-1:0]   action_code_b_q;
  logic [`DCM_SEL_W-1:0]   output_select_a_q;
  logic [`DCM_SEL_W-1:0]   output_select_b_q;
  logic [`DCM_EVT_W-1:0]   event_select_a_q;
  logic [`DCM_EVT_W-1:0]   event_select_b_q;
  // Control and status.
  logic                    compare_unit_enable_q;  // Software enable.
  logic                    enable_prev_q;          // Enable one cycle ago, for edge finding.
  logic                    param_update_request_q; // Pending update, cleared by the device.
  run_state_t              state_q;                // Run state.
  logic                    match_flag_a_q;
  logic                    match_flag_b_q;
  logic                    fault_flag_q;
  fault_t                  fault_code_q;
  logic [31:0]             prev_count_q;           // Counter value one cycle ago.
  logic [2:0]              irq_status_q;           // Sticky interrupt causes.
  logic [2:0]              irq_mask_q;             // Interrupt enables.
  // Combinational terms.
  logic                    wr_ctrl;
  logic                    enable_rise;
  logic                    load;                   // Copy staged values into the active set.
  fault_t                  check_code;             // Result of checking the staged values.
  logic                    hit_a;
  logic                    hit_b;
  logic                    fire_a;
  logic                    fire_b;
  logic                    self_clear;             // A match action clears the counter.
  logic                    ext_clear;              // Any flag clear from outside the match path.
  logic [`DCM_NUM_OUT-1:0] out_d;
  logic [`DCM_NUM_EVT-1:0] evt_a;
  logic [`DCM_NUM_EVT-1:0] evt_b;
  logic [2:0]              irq_set;

  assign wr_ctrl     = i_wr && (i_addr == `DCM_OFF_CTRL);
  assign enable_rise = compare_unit_enable_q && !enable_prev_q;
  // Loads happen on a start or on a pending update while enabled; never while disabled.
  assign load        = enable_rise || (param_update_request_q && compare_unit_enable_q);

  // The staged set is checked each time it would be loaded.
  always_comb
  begin
    if (cfg_a_q[`DCM_CFG_ACT_LO +: `DCM_ACT_W] > `DCM_ACT_MAX ||
        cfg_b_q[`DCM_CFG_ACT_LO +: `DCM_ACT_W] > `DCM_ACT_MAX)
    begin
      check_code = FAULT_ACTION;
    end
    else if (!event_sel_ok(cfg_a_q[`DCM_CFG_EVT_LO +: `DCM_EVT_W]) ||
             !event_sel_ok(cfg_b_q[`DCM_CFG_EVT_LO +: `DCM_EVT_W]))
    begin
      check_code = FAULT_EVENT;
    end
    else if (cmp_a_q == cmp_b_q)
    begin
      // Equal values would make both comparators fire at once; the host must avoid it.
      check_code = FAULT_EQUAL;
    end
    else
    begin
      check_code = FAULT_NONE;
    end
  end

  // Each comparator watches the counter on its own.
  match_detect u_match_a
  (
    .i_prev (prev_count_q),
    .i_cur  (i_count),
    .i_cmp  (act_cmp_a_q),
    .o_hit  (hit_a)
  );

  match_detect u_match_b
  (
    .i_prev (prev_count_q),
    .i_cur  (i_count),
    .i_cmp  (act_cmp_b_q),
    .o_hit  (hit_b)
  );

  // Matches count only while running with a counting counter and no load in progress.
  assign fire_a = hit_a && (state_q == ST_RUN) && compare_unit_enable_q && i_counter_run_enable
                  && !load;
  assign fire_b = hit_b && (state_q == ST_RUN) && compare_unit_enable_q && i_counter_run_enable
                  && !load;

  event_decode u_evt_a
  (
    .i_fire  (fire_a),
    .i_sel   (event_select_a_q),
    .o_lines (evt_a)
  );

  event_decode u_evt_b
  (
    .i_fire  (fire_b),
    .i_sel   (event_select_b_q),
    .o_lines (evt_b)
  );

  assign self_clear = (fire_a && action_clears(action_code_a_q)) ||
                      (fire_b && action_clears(action_code_b_q));
  assign ext_clear  = i_host_stop || i_counter_cleared || enable_rise || load;

  // Output actions: comparator a is applied first, then b, each on its own selected point except ACT_CLR_BOTH, which clears both points.
  always_comb
  begin
    out_d = o_out;
    if (fire_a)
    begin
      case (action_code_a_q)
        ACT_LOW, ACT_LOW_CLR:       out_d[output_select_a_q] = 1'b0;
        ACT_HIGH, ACT_HIGH_CLR:     out_d[output_select_a_q] = 1'b1;
        ACT_TOGGLE, ACT_TOGGLE_CLR: out_d[output_select_a_q] = ~out_d[output_select_a_q];
        ACT_CLR_BOTH:
        begin
          out_d[output_select_a_q] = 1'b0;
          out_d[output_select_b_q] = 1'b0;
        end
        default:                    out_d = out_d;
      endcase
    end
    if (fire_b)
    begin
      case (action_code_b_q)
        ACT_LOW, ACT_LOW_CLR:       out_d[output_select_b_q] = 1'b0;
        ACT_HIGH, ACT_HIGH_CLR:     out_d[output_select_b_q] = 1'b1;
        ACT_TOGGLE, ACT_TOGGLE_CLR: out_d[output_select_b_q] = ~out_d[output_select_b_q];
        ACT_CLR_BOTH:
        begin
          out_d[output_select_a_q] = 1'b0;
          out_d[output_select_b_q] = 1'b0;
        end
        default:                    out_d = out_d;
      endcase
    end
  end

  // Staged registers and the interrupt mask are plain software storage.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cmp_a_q    <= `DCM_RST_WORD;
      cmp_b_q    <= `DCM_RST_WORD;
      cfg_a_q    <= `DCM_RST_WORD;
      cfg_b_q    <= `DCM_RST_WORD;
      irq_mask_q <= `DCM_RST_IRQ;
    end
    else if (i_ce && i_wr)
    begin
      case (i_addr)
        `DCM_OFF_CMP_A:    cmp_a_q    <= i_wdata;
        `DCM_OFF_CMP_B:    cmp_b_q    <= i_wdata;
        `DCM_OFF_CFG_A:    cfg_a_q    <= i_wdata;
        `DCM_OFF_CFG_B:    cfg_b_q    <= i_wdata;
        `DCM_OFF_INT_MASK: irq_mask_q <= i_wdata[2:0];
        default:           cmp_a_q    <= cmp_a_q;
      endcase
    end
  end

  // Enable bit and the update request; the device drops the request once it is applied.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      compare_unit_enable_q  <= 1'b0;
      enable_prev_q          <= 1'b0;
      param_update_request_q <= 1'b0;
    end
    else if (i_ce)
    begin
      enable_prev_q <= compare_unit_enable_q;
      if (wr_ctrl)
      begin
        compare_unit_enable_q <= i_wdata[`DCM_CTRL_ENABLE];
      end
      if (wr_ctrl && i_wdata[`DCM_CTRL_UPDATE])
      begin
        param_update_request_q <= 1'b1;
      end
      else if (load)
      begin
        param_update_request_q <= 1'b0;
      end
    end
  end

  // Active parameter set, copied only on a load; a disabled unit keeps its old set.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      act_cmp_a_q       <= `DCM_RST_WORD;
      act_cmp_b_q       <= `DCM_RST_WORD;
      action_code_a_q   <= ACT_NONE;
      action_code_b_q   <= ACT_NONE;
      output_select_a_q <= '0;
      output_select_b_q <= '0;
      event_select_a_q  <= `DCM_EVT_NONE;
      event_select_b_q  <= `DCM_EVT_NONE;
    end
    else if (i_ce && load && (check_code == FAULT_NONE))
    begin
      act_cmp_a_q       <= cmp_a_q;
      act_cmp_b_q       <= cmp_b_q;
      action_code_a_q   <= cfg_a_q[`DCM_CFG_ACT_LO +: `DCM_ACT_W];
      action_code_b_q   <= cfg_b_q[`DCM_CFG_ACT_LO +: `DCM_ACT_W];
      output_select_a_q <= cfg_a_q[`DCM_CFG_SEL_LO +: `DCM_SEL_W];
      output_select_b_q <= cfg_b_q[`DCM_CFG_SEL_LO +: `DCM_SEL_W];
      event_select_a_q  <= cfg_a_q[`DCM_CFG_EVT_LO +: `DCM_EVT_W];
      event_select_b_q  <= cfg_b_q[`DCM_CFG_EVT_LO +: `DCM_EVT_W];
    end
  end

  // Run state: a failed check parks the unit until software drops the enable.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q      <= ST_IDLE;
      fault_flag_q <= 1'b0;
      fault_code_q <= FAULT_NONE;
    end
    else if (i_ce)
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (load && (check_code != FAULT_NONE))
          begin
            state_q      <= ST_FAULT;
            fault_flag_q <= 1'b1;
            fault_code_q <= check_code;
          end
          else if (load)
          begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (!compare_unit_enable_q)
          begin
            state_q <= ST_IDLE;
          end
          else if (load && (check_code != FAULT_NONE))
          begin
            state_q      <= ST_FAULT;
            fault_flag_q <= 1'b1;
            fault_code_q <= check_code;
          end
        end
        ST_FAULT:
        begin
          if (!compare_unit_enable_q)
          begin
            state_q      <= ST_IDLE;
            fault_flag_q <= 1'b0;
            fault_code_q <= FAULT_NONE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Match flags: a new match beats an outside clear, but a clear caused by the action wins.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      match_flag_a_q <= 1'b0;
      match_flag_b_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (self_clear)
      begin
        match_flag_a_q <= 1'b0;
        match_flag_b_q <= 1'b0;
      end
      else
      begin
        match_flag_a_q <= fire_a || (match_flag_a_q && !ext_clear);
        match_flag_b_q <= fire_b || (match_flag_b_q && !ext_clear);
      end
    end
  end

  // Outputs act one cycle after the match, far inside the allowed delay.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      prev_count_q    <= `DCM_RST_WORD;
      o_out           <= '0;
      o_event         <= '0;
      o_counter_clear <= 1'b0;
    end
    else if (i_ce)
    begin
      prev_count_q    <= i_count;
      o_out           <= out_d;
      o_event         <= evt_a | evt_b;
      o_counter_clear <= self_clear;
    end
  end

  // Interrupt causes are sticky, cleared by writing one; a new event wins over the clear.
  assign irq_set = {fault_flag_q == 1'b0 && state_q == ST_IDLE && load &&
                    check_code != FAULT_NONE, fire_b, fire_a};

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      irq_status_q <= `DCM_RST_IRQ;
      o_irq        <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_wr && (i_addr == `DCM_OFF_INT_STATUS))
      begin
        irq_status_q <= (irq_status_q & ~i_wdata[2:0]) | irq_set;
      end
      else
      begin
        irq_status_q <= irq_status_q | irq_set;
      end
      o_irq <= |((irq_status_q | irq_set) & irq_mask_q);
    end
  end

  // Read port: data stands in the cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= `DCM_RST_WORD;
    end
    else if (i_ce)
    begin
      o_rdata <= '0;
      if (i_rd)
      begin
        case (i_addr)
          `DCM_OFF_CTRL:       o_rdata <= {30'h0000_0000, param_update_request_q,
                                           compare_unit_enable_q};
          `DCM_OFF_STATUS:     o_rdata <= {12'h000, o_out, 4'h0, fault_code_q, 5'h00,
                                           fault_flag_q, match_flag_b_q, match_flag_a_q};
          `DCM_OFF_CMP_A:      o_rdata <= cmp_a_q;
          `DCM_OFF_CMP_B:      o_rdata <= cmp_b_q;
          `DCM_OFF_CFG_A:      o_rdata <= cfg_a_q;
          `DCM_OFF_CFG_B:      o_rdata <= cfg_b_q;
          `DCM_OFF_INT_STATUS: o_rdata <= {29'h0000_0000, irq_status_q};
          `DCM_OFF_INT_MASK:   o_rdata <= {29'h0000_0000, irq_mask_q};
          default:             o_rdata <= '0;
        endcase
      end
    end
  end

endmodule

/* testbench/dcm_chk.sv */
// Port-level assertions of the dual compare unit.
`timescale 1ns/1ps
module dcm_chk
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] i_count,
  input wire logic        i_counter_run_enable,
  input wire logic [31:0] o_rdata,
  input wire logic        o_counter_clear,
  input wire logic [3:0]  o_out,
  input wire logic [31:0] o_event
);
  logic en_q; // Copy of the enable bit, taken from bus writes.
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Follow the enable bit so the hold rule can be judged from the ports.
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      en_q <= 1'b0;
    else if (i_ce && i_wr && i_addr == 8'h00)
      en_q <= i_wdata[0];
  chk_evt_onehot: assert property ($onehot0(o_event))
    else $error("two event lines at once");
  chk_evt_pulse: assert property (|o_event |=> o_event != $past(o_event))
    else $error("event line held high");
  chk_evt_gate: assert property (|o_event |-> $past(en_q) && $past(i_counter_run_enable))
    else $error("event while disabled");
  chk_evt_step: assert property (|o_event |->
    ($past(i_count) - $past(i_count, 2)) inside {32'h0000_0001, 32'hFFFF_FFFF})
    else $error("event without a compare arrival");
  chk_clr_step: assert property (o_counter_clear |->
    ($past(i_count) - $past(i_count, 2)) inside {32'h0000_0001, 32'hFFFF_FFFF})
    else $error("counter clear without a compare arrival");
  chk_clr_pulse: assert property (o_counter_clear |=> !o_counter_clear)
    else $error("counter clear longer than one cycle");
  chk_out_hold: assert property (!en_q |=> $stable(o_out))
    else $error("output point moved while disabled");
  chk_rd_idle: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside the read cycle");
endmodule

bind dual_compare_match_output dcm_chk chk_u (.*);

/* testbench/dcm_host.sv */
// Host model that drives the register port of the compare unit.
`timescale 1ns/1ps
module dcm_host
(
  input  wire logic        i_clk,
  input  wire logic [31:0] i_rdata,
  output logic      [7:0]  o_addr,
  output logic      [31:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  // The bus is idle at time zero.
  initial
  begin
    o_addr  = 8'h00;
    o_wdata = 32'h0000_0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // One strobe cycle; callers load parameters before the update bit.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so take them there.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule

/* testbench/dual_compare_match_output_tb.sv */
// Self-checking bench of the dual compare unit.
`timescale 1ns/1ps
module dual_compare_match_output_tb;
  logic        clk;
  logic        rst_n;
  logic        stop;
  logic        xclr;
  logic        run;
  logic        wr;
  logic        rd;
  logic        cclr;
  logic        irq;
  logic [7:0]  addr;
  logic [3:0]  out;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] cnt;
  logic [31:0] evt;
  logic [31:0] d;
  int          err_total;
  int          num_checks;
  // Action, output select, event select, expected points, expected clear.
  typedef struct packed {logic [3:0] a; logic [1:0] s; logic [8:0] e; logic [3:0] o; logic c;} row_t;
  row_t rows [9] = '{'{4'h0, 2'h0, 9'h000, 4'h0, 1'b0}, '{4'h1, 2'h1, 9'h190, 4'h0, 1'b0},
    '{4'h2, 2'h2, 9'h1AF, 4'h4, 1'b0}, '{4'h3, 2'h3, 9'h191, 4'h8, 1'b0},
    '{4'h4, 2'h0, 9'h000, 4'h0, 1'b1}, '{4'h5, 2'h1, 9'h000, 4'h2, 1'b1},
    '{4'h6, 2'h2, 9'h000, 4'h4, 1'b1}, '{4'h7, 2'h3, 9'h000, 4'h0, 1'b1},
    '{4'h8, 2'h0, 9'h000, 4'h0, 1'b1}};
  dual_compare_match_output dut_u
  (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_count(cnt), .i_counter_run_enable(run),
    .i_counter_cleared(xclr), .i_host_stop(stop), .o_counter_clear(cclr), .o_out(out),
    .o_event(evt), .o_irq(irq)
  );
  dcm_host host
  (
    .i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd)
  );
  // Compare, count and report a mismatch at once.
  task automatic ck(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Reset for two cycles with the counter at zero.
  task automatic rst;
    @(posedge clk);
    rst_n <= 1'b0;
    cnt   <= 32'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // Compare values 10 and 20 stay distinct, then the unit is started.
  task automatic go(input logic [31:0] fa, input logic [31:0] fb);
    host.wr(8'h08, 32'hA);
    host.wr(8'h0C, 32'h14);
    host.wr(8'h10, fa);
    host.wr(8'h14, fb);
    host.wr(8'h00, 32'h1);
    repeat (2) @(posedge clk);
  endtask
  // Step the counter a to b; the action shows one cycle after b is taken.
  task automatic mv(input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    cnt <= a;
    @(posedge clk);
    cnt <= b;
    @(posedge clk);
    #1;
  endtask
  task automatic fl(input logic [1:0] x);
    host.rd(8'h04, d);
    ck(d[1:0], x);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // The whole run needs a few hundred cycles; this cuts a hang.
  initial
  begin
    #100000;
    err_total++;
    stop_test();
  end
  initial
  begin
    rst_n = 1'b0;
    stop = 1'b0;
    xclr = 1'b0;
    run = 1'b1;
    cnt = 32'h0;
    err_total = 0;
    num_checks = 0;
    foreach (rows[i])
    begin
      rst();
      go({7'h00, rows[i].e, 10'h000, rows[i].s, rows[i].a}, 32'h0);
      mv(32'hA, 32'hB);
      ck(out, rows[i].o);
      ck(cclr, rows[i].c);
      ck(evt, rows[i].e == 9'h000 ? 32'h0 : 32'h1 << (rows[i].e - 9'h190));
      fl({1'b0, rows[i].a < 4'h4});
    end
    // Toggle on one comparator, toggle with clear on the other.
    rst();
    host.wr(8'h1C, 32'h1);
    go(32'h0190_0003, 32'h16);
    mv(32'hA, 32'hB);
    ck(out, 4'h1);
    ck(cclr, 1'b0);
    #10;
    ck(irq, 1'b1);
    mv(32'h14, 32'h15);
    ck(out, 4'h3);
    ck(cclr, 1'b1);
    fl(2'b00);
    host.wr(8'h18, 32'h1);
    #11;
    ck(irq, 1'b0);
    mv(32'hA, 32'hB);
    ck(out, 4'h2);
    // A stopped counter gives no match, even when it crosses the compare value.
    @(posedge clk);
    run <= 1'b0;
    mv(32'hA, 32'hB);
    ck(out, 4'h2);
    ck(evt, 32'h0);
    @(posedge clk);
    run <= 1'b1;
    // Drive high, then clear both points.
    rst();
    go(32'h22, 32'h38);
    mv(32'hA, 32'hB);
    ck(out, 4'h4);
    ck(cclr, 1'b0);
    mv(32'h14, 32'h15);
    ck(out, 4'h0);
    ck(cclr, 1'b1);
    fl(2'b00);
    // Stop, outside clear, disable and enable rise.
    rst();
    go(32'h3, 32'h0);
    mv(32'hA, 32'hB);
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    fl(2'b00);
    mv(32'hA, 32'hB);
    @(posedge clk);
    xclr <= 1'b1;
    @(posedge clk);
    xclr <= 1'b0;
    fl(2'b00);
    mv(32'hA, 32'hB);
    host.wr(8'h00, 32'h0);
    mv(32'hA, 32'hB);
    ck(out, 4'h1);
    ck(evt, 32'h0);
    host.wr(8'h00, 32'h1);
    fl(2'b00);
    // New compare value loaded, then the update bit requested.
    rst();
    go(32'h3, 32'h0);
    mv(32'hA, 32'hB);
    host.wr(8'h08, 32'h1E);
    host.wr(8'h00, 32'h3);
    d = 32'h2;
    for (int k = 0; k < 20 && d[1] !== 1'b0; k++)
      host.rd(8'h00, d);
    ck(d[1], 1'b0);
    fl(2'b00);
    mv(32'hA, 32'hB);
    ck(out, 4'h1);
    mv(32'h1E, 32'h1F);
    ck(out, 4'h0);
    // Bad action, bad event select, equal compare values.
    for (int k = 0; k < 3; k++)
    begin
      rst();
      host.wr(8'h1C, 32'h4);
      host.wr(8'h08, 32'hA);
      host.wr(8'h0C, k == 2 ? 32'hA : 32'h14);
      host.wr(8'h10, k == 0 ? 32'h9 : k == 1 ? 32'h018F_0000 : 32'h0);
      host.wr(8'h00, 32'h1);
      repeat (3) @(posedge clk);
      host.rd(8'h04, d);
      ck(d[11:8], k + 1);
      ck(d[2], 1'b1);
      ck(irq, 1'b1);
    end
    host.wr(8'h18, 32'h4);
    #11;
    ck(irq, 1'b0);
    host.rd(8'h40, d);
    ck(d, 32'h0);
    stop_test();
  end
endmodule
